// ---- shared/cell_if.sv ----
// Purpose: gate outputs and function controls between cell modules
// Assumes: single clock domain
// Notes:   gate bits already carry their polarity
`timescale 1ns/100ps
interface cell_if;
  logic [3:0] gate;
  logic [2:0] mode;
  logic       enable;
  logic       result;
  modport ctl (output gate, output mode, output enable, input result);
  modport fn  (input gate, input mode, input enable, output result);
endinterface : cell_if

// ---- shared/clc_defines.svh ----
// Purpose: offsets, field positions, masks and reset values of the logic cell
// Assumes: byte addresses on a 32-bit bus, one aligned word per register
// Notes:   each register except status has clear, set and invert aliases at +4, +8 and +C
`ifndef CLC_DEFINES_SVH
`define CLC_DEFINES_SVH
`define CLC_CTRL_OFS     4'h0
`define CLC_SEL_OFS      4'h1
`define CLC_GATE_OFS     4'h2
`define CLC_STAT_OFS     4'h3
`define CLC_MASK_OFS     4'h4
`define CLC_OP_WRITE     2'h0
`define CLC_OP_CLR       2'h1
`define CLC_OP_SET       2'h2
`define CLC_OP_INV       2'h3
`define CLC_RESET_VAL    32'h0000_0000
`define CLC_CTRL_RMASK   32'h000F_8CE7
`define CLC_CTRL_WMASK   32'h000F_8CA7
`define CLC_SEL_MASK     32'h0000_7777
`define CLC_GATE_MASK    32'hFFFF_FFFF
`define CLC_STAT_MASK    32'h0000_0003
`define CLC_MODE_LSB     0
`define CLC_INV_BIT      5
`define CLC_STATE_BIT    6
`define CLC_PINOE_BIT    7
`define CLC_FALL_BIT     10
`define CLC_RISE_BIT     11
`define CLC_EN_BIT       15
`define CLC_GINV_LSB     16
`define CLC_SEL_STRIDE   4
`define CLC_GATE_STRIDE  8
`define CLC_STAT_RISE    0
`define CLC_STAT_FALL    1
`define CLC_HTRANS_NSEQ  2'h2
`define CLC_HSIZE_WORD   3'h2
`endif

// ---- shared/clc_pkg.sv ----
// Purpose: types shared by the logic cell modules
// Assumes: constants come from clc_defines.svh
// Notes:   state of each module is one packed struct
package clc_pkg;
  typedef enum logic [2:0] {
    MODE_AND_OR = 3'h0, MODE_OR_XOR = 3'h1, MODE_AND4  = 3'h2, MODE_SR    = 3'h3,
    MODE_DFF_SR = 3'h4, MODE_DFF2_R = 3'h5, MODE_JK_R  = 3'h6, MODE_LATCH = 3'h7
  } func_mode_t;

  typedef struct packed {
    logic q;
    logic clk_prev;
  } fn_state_t;

  typedef struct packed {
    logic [31:0] ctrl, sel, gate, stat, mask;
    logic [31:0] pool_s1, pool_s2;
    logic        ph_wr;
    logic [7:0]  ph_addr;
    logic [31:0] rdata;
    logic        ready;
    logic        cell_out, cell_prev, pin_out, pin_oe, irq;
  } clc_state_t;
endpackage : clc_pkg

// ---- tb/configurable_logic_cell_tb.sv ----
// Purpose: self-checking bench of the logic cell over AHB-Lite
// Assumes: zero-wait slave, cell output three edges after a pool change
// Notes:   outputs are sampled on the falling edge, except read data and checks right after a register read
`timescale 1ns/100ps
`include "clc_defines.svh"
`define CHK(got, exp) \
  begin comparisons++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module configurable_logic_cell_tb;
  import clc_pkg::*;
  localparam logic [31:0] A_CTRL = 32'h00, A_SEL = 32'h10, A_GATE = 32'h20;
  localparam logic [31:0] A_STAT = 32'h30, A_MASK = 32'h40;
  logic        ref_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, source_pool, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        cell_out, pin_out, pin_oe, irq;
  logic [3:0]  level;
  logic [11:0] pick;
  int          fails, comparisons;
  assign hready = hreadyout;
  configurable_logic_cell u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .source_pool(source_pool), .cell_out(cell_out), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq(irq));
  pool_model u_pool (.ref_clk(ref_clk), .level(level), .pick(pick),
    .source_pool(source_pool));
  always #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [31:0] adr, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= adr;
    hwrite <= wr;
    htrans <= `CLC_HTRANS_NSEQ;
    hsize  <= `CLC_HSIZE_WORD;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic chk_reg(input logic [31:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, adr, 32'h0, r);
    `CHK(r, exp)
  endtask : chk_reg
  task automatic drive(input logic [3:0] v);
    @(posedge ref_clk);
    level <= v;
    repeat (5) @(negedge ref_clk);
  endtask : drive
  function automatic logic fexp(input int m, input logic [3:0] g);
    case (m)
      0: return (g[0] & g[1]) | (g[2] & g[3]);
      1: return (g[0] | g[1]) ^ (g[2] | g[3]);
      default: return &g;
    endcase
  endfunction : fexp
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] adrs [5] = '{A_CTRL, A_SEL, A_GATE, A_STAT, A_MASK};
    foreach (adrs[i])
      chk_reg(adrs[i], 32'h0);
    `CHK({cell_out, pin_out, pin_oe, irq, hreadyout, hresp}, 6'h02)
    bus(1'b1, 32'h50, 32'hFFFF_FFFF, rd);
    chk_reg(32'h50, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    bus(1'b1, A_CTRL, 32'hFFFF_7FFF, rd);
    chk_reg(A_CTRL, 32'h000F_0CA7);
    bus(1'b1, A_CTRL, 32'h0, rd);
    bus(1'b1, A_SEL, 32'hFFFF_FFFF, rd);
    chk_reg(A_SEL, 32'h0000_7777);
    bus(1'b1, A_SEL, 32'h0000_1234, rd);
    bus(1'b1, A_SEL + 32'h4, 32'h0000_0030, rd);
    chk_reg(A_SEL, 32'h0000_1204);
    bus(1'b1, A_SEL + 32'h8, 32'h0000_0070, rd);
    chk_reg(A_SEL, 32'h0000_1274);
    bus(1'b1, A_SEL + 32'hC, 32'h0000_5001, rd);
    chk_reg(A_SEL, 32'h0000_4275);
    bus(1'b1, A_GATE, 32'hFFFF_FFFF, rd);
    chk_reg(A_GATE, 32'hFFFF_FFFF);
    $display("test registers done");
  endtask : t_regs
  // every pick differs from zero so a stuck select field reads noise
  task automatic t_comb;
    logic [3:0] ginv, g;
    logic       e;
    pick <= {3'd5, 3'd2, 3'd7, 3'd3};
    bus(1'b1, A_SEL, 32'h0000_5273, rd);
    bus(1'b1, A_GATE, 32'h4020_0802, rd);
    for (int m = 0; m < 3; m++)
    begin
      ginv = 4'(m * 5);
      bus(1'b1, A_CTRL, 32'h8000 | (32'(ginv) << 16) | (32'(m == 1) << 5) | 32'(m), rd);
      for (int v = 0; v < 16; v++)
      begin
        drive(4'(v));
        g = {~v[3], 3'(v)} ^ ginv;
        e = fexp(m, g) ^ (m == 1);
        `CHK(cell_out, e)
      end
    end
    chk_reg(A_CTRL, 32'h000A_8002 | (32'(e) << 6));
    $display("test combinational done");
  endtask : t_comb
  // entries are mode, levels, expected output; every stored-state mode is covered
  task automatic t_seq;
    logic [7:0] st [26] = '{8'h60, 8'h70, 8'h73, 8'h71, 8'h62,
                            8'h98, 8'h94, 8'h97, 8'h93, 8'h91, 8'h92,
                            8'hA0, 8'hA7, 8'hA8,
                            8'hC0, 8'hD7, 8'hC1, 8'hC2, 8'hC0, 8'hC7,
                            8'hF1, 8'hF2, 8'hF7, 8'hF5, 8'hF8, 8'hE1};
    logic [2:0] cur = 3'h0;
    for (int i = 0; i < 26; i++)
    begin
      if (st[i][7:5] != cur)
        bus(1'b1, A_CTRL, 32'h8000 | 32'(st[i][7:5]), rd);
      cur = st[i][7:5];
      drive(st[i][4:1]);
      `CHK(cell_out, st[i][0])
    end
    $display("test sequential done");
  endtask : t_seq
  task automatic t_irq;
    bus(1'b1, A_CTRL, 32'h0000_8882, rd);
    drive(4'h0);
    bus(1'b1, A_MASK, 32'h3, rd);
    bus(1'b1, A_STAT, 32'h3, rd);
    drive(4'h7);
    `CHK({irq, pin_out, pin_oe}, 3'h7)
    chk_reg(A_STAT, 32'h1);
    drive(4'h0);
    chk_reg(A_STAT, 32'h1);
    bus(1'b1, A_STAT, 32'h1, rd);
    chk_reg(A_STAT, 32'h0);
    `CHK(irq, 1'b0)
    bus(1'b1, A_MASK, 32'h0, rd);
    bus(1'b1, A_CTRL + 32'h8, 32'h400, rd);
    drive(4'h7);
    drive(4'h0);
    chk_reg(A_STAT, 32'h3);
    `CHK(irq, 1'b0)
    bus(1'b1, A_MASK, 32'h2, rd);
    repeat (2) @(negedge ref_clk);
    `CHK(irq, 1'b1)
    bus(1'b1, A_STAT + 32'h4, 32'h3, rd);
    repeat (2) @(negedge ref_clk);
    `CHK(irq, 1'b0)
    drive(4'h7);
    bus(1'b1, A_CTRL + 32'h4, 32'h8000, rd);
    repeat (3) @(negedge ref_clk);
    `CHK({cell_out, pin_out, pin_oe}, 3'h0)
    chk_reg(A_CTRL, 32'h0000_0C82);
    $display("test interrupt done");
  endtask : t_irq
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  initial
  begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    level = 4'h8;
    pick = 12'h0;
    fails = 0;
    comparisons = 0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_comb();
    t_seq();
    t_irq();
    results();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    results();
  end
endmodule : configurable_logic_cell_tb

// ---- tb/pool_model.sv ----
// Purpose: far-side peripherals and pins feeding the source pool
// Assumes: one picked candidate per mux carries the commanded level
// Notes:   unpicked candidates toggle every cycle so a wrong pick shows up
`timescale 1ns/100ps
module pool_model (
  // clock
  input  wire logic        ref_clk,
  // commanded levels and picks
  input  wire logic [3:0]  level,
  input  wire logic [11:0] pick,
  // pool to the cell
  output logic      [31:0] source_pool
);
  logic [31:0] noise_reg = 32'hA5C3_5A3C;
  always @(posedge ref_clk)
  begin
    noise_reg <= ~noise_reg;
  end
  always_comb
  begin
    source_pool = noise_reg;
    for (int i = 0; i < 4; i++)
    begin
      source_pool[8*i + int'(pick[3*i +: 3])] = level[i];
    end
  end
endmodule : pool_model

// ---- verilog/configurable_logic_cell.sv ----
// Purpose: configurable logic cell with AHB-Lite register slave
// Assumes: source pool arrives asynchronously and is synchronised here
// Notes:   zero-wait-state slave; every response is OKAY
`timescale 1ns/100ps
`include "clc_defines.svh"

// Notes on behaviour
// - four gates feed the function, drawing from a 32-signal pool via four muxes
// - each mux picks one of its eight candidates by its own select field
// - source select holds four independent select fields, one per mux
// - each mux offers its pick both true and inverted to the gates
// - each gate ORs the enabled true and inverted mux outputs, then applies its gate polarity bit
// - control holds enable, edge irq enables, pin enable, polarity, function
// - control also inverts individual gate outputs before the function
// - output drives pin and peripherals continuously without software help
// - writes at +4, +8, +C clear, set or invert the written ones; status clears them at every alias
// - unimplemented bits read zero and ignore writes
// - three-bit function field selects one of eight cell functions
// - with enable clear cell, pin and pin enable outputs are zero; irq still follows unmasked status
// - rising or falling output edge sets its status flag when its enable is set; irq also needs the mask bit
// - each gate polarity bit inverts its gate before the function
module configurable_logic_cell
  import clc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // source pool, eight candidates per mux
  input  wire logic [31:0] source_pool,
  // cell outputs
  output logic             cell_out,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             irq
);
  import clc_pkg::*;

  clc_state_t q, n;
  logic [3:0] mux_val;
  logic [3:0] gate_pol;
  logic       ctl_en, rise_ev, fall_ev, addr_take;
  logic [3:0] wr_reg;
  logic [1:0] wr_op;
  logic [31:0] wv;

  cell_if cif ();

  ////////////////////////////////////////////////////////////////////////////
  // register access helpers

  function automatic logic [31:0] apply_op(input logic [31:0] cur,
                                           input logic [31:0] val,
                                           input logic [31:0] wmask,
                                           input logic [1:0]  op);
    logic [31:0] v;
    v = val & wmask;
    case (op)
      `CLC_OP_CLR: apply_op = cur & ~v;
      `CLC_OP_SET: apply_op = cur | v;
      `CLC_OP_INV: apply_op = cur ^ v;
      default:     apply_op = (cur & ~wmask) | v;
    endcase
  endfunction : apply_op

  function automatic logic [31:0] reg_read(input clc_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a[7:4])
      `CLC_CTRL_OFS:
      begin
        r = s.ctrl & `CLC_CTRL_RMASK;
        r[`CLC_STATE_BIT] = s.cell_out;
      end
      `CLC_SEL_OFS:  r = s.sel & `CLC_SEL_MASK;
      `CLC_GATE_OFS: r = s.gate & `CLC_GATE_MASK;
      `CLC_STAT_OFS: r = s.stat & `CLC_STAT_MASK;
      `CLC_MASK_OFS: r = s.mask & `CLC_STAT_MASK;
      default:       r = '0;
    endcase
    reg_read = r;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // source muxes and gates

  // source mux pick
  // pool split in four groups
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      mux_val[i] = q.pool_s2[8*i + int'(q.sel[`CLC_SEL_STRIDE*i +: 3])];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_gate
      source_gate u_gate (
        .src_val     (mux_val),
        .term_en     (q.gate[`CLC_GATE_STRIDE*gi +: 8]),
        .gate_invert (q.ctrl[`CLC_GINV_LSB + gi]),
        .gate_out    (gate_pol[gi])
      );
    end
  endgenerate

  assign ctl_en     = q.ctrl[`CLC_EN_BIT];
  assign cif.gate   = gate_pol;
  assign cif.mode   = q.ctrl[`CLC_MODE_LSB +: 3];
  assign cif.enable = ctl_en;

  logic_function u_func (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .cif     (cif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  assign addr_take = hsel & htrans[1] & hready;
  assign wr_reg    = q.ph_addr[7:4];
  assign wr_op     = q.ph_addr[3:2];
  assign wv        = hwdata;

  always_comb
  begin
    n = q;
    // two flops before any logic reads the pool
    n.pool_s1 = source_pool;
    n.pool_s2 = q.pool_s1;
    n.ready   = 1'b1;
    n.ph_wr   = 1'b0;

    // data phase of a write
    // write, clear, set and invert aliases
    // write masks keep unimplemented bits zero
    if (q.ph_wr)
    begin
      case (wr_reg)
        // gate polarity bits live here too
        `CLC_CTRL_OFS: n.ctrl = apply_op(q.ctrl, wv, `CLC_CTRL_WMASK, wr_op);
        `CLC_SEL_OFS:  n.sel  = apply_op(q.sel, wv, `CLC_SEL_MASK, wr_op);
        `CLC_GATE_OFS: n.gate = apply_op(q.gate, wv, `CLC_GATE_MASK, wr_op);
        `CLC_MASK_OFS: n.mask = apply_op(q.mask, wv, `CLC_STAT_MASK, wr_op);
        // status clears on any written one, whatever the alias
        `CLC_STAT_OFS: n.stat = q.stat & ~(wv & `CLC_STAT_MASK);
        default:       n.stat = n.stat;
      endcase
    end

    n.cell_out  = ctl_en & (cif.result ^ q.ctrl[`CLC_INV_BIT]);
    n.cell_prev = q.cell_out;

    rise_ev = q.cell_out & ~q.cell_prev & q.ctrl[`CLC_RISE_BIT];
    fall_ev = ~q.cell_out & q.cell_prev & q.ctrl[`CLC_FALL_BIT];
    // set after clear so an event in the clearing cycle survives
    if (rise_ev)
      n.stat[`CLC_STAT_RISE] = 1'b1;
    if (fall_ev)
      n.stat[`CLC_STAT_FALL] = 1'b1;

    n.pin_out = n.cell_out & n.ctrl[`CLC_PINOE_BIT];
    n.pin_oe  = n.ctrl[`CLC_EN_BIT] & n.ctrl[`CLC_PINOE_BIT];
    n.irq     = |(n.stat & n.mask & `CLC_STAT_MASK);

    // address phase; read data sees this cycle's write already applied
    if (addr_take)
    begin
      n.ph_wr   = hwrite;
      n.ph_addr = haddr[7:0];
      if (!hwrite)
        n.rdata = reg_read(n, haddr[7:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= n;
  end

  assign hrdata    = q.rdata;
  assign hreadyout = q.ready;
  assign hresp     = 1'b0;
  assign cell_out  = q.cell_out;
  assign pin_out   = q.pin_out;
  assign pin_oe    = q.pin_oe;
  assign irq       = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_wr_addr(logic [7:0] a);
    hsel && htrans == `CLC_HTRANS_NSEQ && hwrite && hready && haddr[7:0] == a;
  endsequence

  sequence s_wr_done(logic [7:0] a);
    s_wr_addr(a) ##1 1'b1;
  endsequence

  property p_disabled_low;
    !ctl_en |=> (!cell_out && !pin_out);
  endproperty
  a_disabled_low: assert property (p_disabled_low)
    else $error("cell output high while disabled");

  property p_rise_flag;
    (q.cell_out && !q.cell_prev && q.ctrl[`CLC_RISE_BIT]) |=> q.stat[`CLC_STAT_RISE];
  endproperty
  a_rise_flag: assert property (p_rise_flag)
    else $error("rising edge not flagged");

  property p_fall_flag;
    (!q.cell_out && q.cell_prev && q.ctrl[`CLC_FALL_BIT]) |=> q.stat[`CLC_STAT_FALL];
  endproperty
  a_fall_flag: assert property (p_fall_flag)
    else $error("falling edge not flagged");

  property p_irq_level;
    irq == (|(q.stat & q.mask & `CLC_STAT_MASK));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked status without interrupt");

  property p_set_alias;
    s_wr_done({`CLC_CTRL_OFS, `CLC_OP_SET, 2'h0}) |=>
      ((q.ctrl & $past(hwdata) & `CLC_CTRL_WMASK) == ($past(hwdata) & `CLC_CTRL_WMASK));
  endproperty
  a_set_alias: assert property (p_set_alias)
    else $error("set alias did not set bits");

  property p_clr_alias;
    s_wr_done({`CLC_SEL_OFS, `CLC_OP_CLR, 2'h0}) |=> ((q.sel & $past(hwdata)) == 32'h0);
  endproperty
  a_clr_alias: assert property (p_clr_alias)
    else $error("clear alias did not clear bits");

  property p_unimpl_zero;
    ((q.sel & ~`CLC_SEL_MASK) == 32'h0) && ((q.ctrl & ~`CLC_CTRL_WMASK) == 32'h0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bits became set");

  property p_gate_empty;
    (q.gate[7:0] == 8'h00) |-> (gate_pol[0] == q.ctrl[`CLC_GINV_LSB]);
  endproperty
  a_gate_empty: assert property (p_gate_empty)
    else $error("disabled terms reached gate one");

  property p_and4;
    (ctl_en && cif.mode == MODE_AND4 && !q.ctrl[`CLC_INV_BIT]) |=> cell_out == $past(&gate_pol);
  endproperty
  a_and4: assert property (p_and4)
    else $error("four-input AND gave wrong output");

  property p_pin_enable;
    pin_oe == (ctl_en && q.ctrl[`CLC_PINOE_BIT]);
  endproperty
  a_pin_enable: assert property (p_pin_enable)
    else $error("pin enable did not follow control");

endmodule : configurable_logic_cell

// ---- verilog/logic_function.sv ----
// Purpose: selectable cell function over four gate signals
// Assumes: flip-flop modes clock on a rising gate 1 seen at ref_clk
// Notes:   latches and flip-flops are emulated synchronously; resets dominate sets
`timescale 1ns/100ps
module logic_function
  import clc_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // gates in, result out
  cell_if.fn        cif
);
  fn_state_t q, n;
  logic [3:0] g;
  logic       edge1;

  always_comb
  begin
    g     = cif.gate;
    n     = q;
    edge1 = g[0] & ~q.clk_prev;
    n.clk_prev = g[0];
    case (func_mode_t'(cif.mode))
      MODE_SR:     if (g[2] | g[3]) n.q = 1'b0; else if (g[0] | g[1]) n.q = 1'b1;
      MODE_DFF_SR: if (g[2]) n.q = 1'b0; else if (g[3]) n.q = 1'b1; else if (edge1) n.q = g[1];
      MODE_DFF2_R: if (g[2]) n.q = 1'b0; else if (edge1) n.q = g[1] & g[3];
      MODE_JK_R:
        if (g[2]) n.q = 1'b0;
        else if (edge1) n.q = (g[1] & ~q.q) | (~g[3] & q.q);
      MODE_LATCH:  if (g[2]) n.q = 1'b0; else if (g[3]) n.q = 1'b1; else if (g[0]) n.q = g[1];
      default:     n.q = 1'b0;
    endcase
    if (!cif.enable)
      n = '0;
    case (func_mode_t'(cif.mode))
      MODE_AND_OR: cif.result = (g[0] & g[1]) | (g[2] & g[3]);
      MODE_OR_XOR: cif.result = (g[0] | g[1]) ^ (g[2] | g[3]);
      MODE_AND4:   cif.result = &g;
      default:     cif.result = n.q;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= n;
  end
endmodule : logic_function

// ---- verilog/source_gate.sv ----
// Purpose: one input gate: OR of enabled true/inverted source terms
// Assumes: term byte holds (inverted, true) pairs for sources 1..4
// Notes:   purely combinational
`timescale 1ns/100ps
module source_gate (
  // sources and configuration
  input  wire logic [3:0] src_val,
  input  wire logic [7:0] term_en,
  input  wire logic       gate_invert,
  // result
  output logic            gate_out
);
  logic [7:0] terms;

  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      terms[2*k]   = ~src_val[k];
      terms[2*k+1] = src_val[k];
    end
    gate_out = (|(terms & term_en)) ^ gate_invert;
  end
endmodule : source_gate
